/* File: prd_ref_ctrl.sv */
// Top of the reference divider and control block
// What this block does
// - Status pin is OR of the software-selected lock and clamp flags.
// - A serial transaction is framed by the chip select low window.
// - Serial input bits are sampled at rising serial clock edges, except in the data phase of a read.
// - Serial output is released except while read data is shifted out.
// - Low mute pin silences the RF output while bias stays up.
// - Modulator can be switched off for plain integer division.
// - Reference divided by a 5-bit ratio from 1 to 31.
// - Divide ratio is taken directly from the field at address 6.
// - Lock flags readable on the status pin and at address 0.
`timescale 1ns/1ps
`default_nettype none
module prd_ref_ctrl (
  // Clock and reset
  input  wire logic       MCLK,
  input  wire logic       SYS_RST,
  // Register port
  input  wire logic [6:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Serial port
  input  wire logic       CS_N,
  input  wire logic       SCLK,
  input  wire logic       SDI,
  output logic            SDO,
  output logic            SDO_OE,
  // Analog status flags
  input  wire logic       OUT_OF_LOCK_FLAG,
  input  wire logic       IN_LOCK_FLAG,
  input  wire logic       HIGH_CLAMP_FLAG,
  input  wire logic       LOW_CLAMP_FLAG,
  // Reference and mute pins
  input  wire logic       REF_IN,
  input  wire logic       MUTE_N,
  // Control outputs
  output logic            STAT,
  output logic            IRQ,
  output logic            RF_MUTE,
  output logic            DSM_OFF,
  output logic      [1:0] REF_FILTER_SELECT,
  output logic            REF_GAIN_BOOST,
  output logic            PFD_REF_PULSE
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  flag_m;
    logic [3:0]  flag_q;
    logic [3:0]  flag_d;
    logic        ref_m;
    logic        ref_q;
    logic        ref_d;
    logic        ref_rise;
    logic        ref_lost;
    logic        ref_lost_d;
    logic [11:0] ref_idle;
    logic        mute_m;
    logic        mute_q;
    logic [3:0]  stat_sel;
    logic [4:0]  ref_div;
    logic [1:0]  ref_filter_select;
    logic        boost;
    logic        dsm_off;
    logic [4:0]  irq_stat;
    logic [4:0]  irq_mask;
    logic [7:0]  rdata;
    logic        stat;
    logic        irq;
    logic        rf_mute;
    logic        restart;
  } prd_main_type;

  localparam prd_main_type MAIN_RST = '{
    mute_m:   1'b1,
    mute_q:   1'b1,
    stat_sel: prd_pkg::STAT_SEL_RESET,
    ref_div:  prd_pkg::RD_RESET,
    irq_mask: prd_pkg::MASK_RESET,
    default:  '0
  };

  prd_main_type s;
  prd_main_type next_s;
  logic [3:0]   flag_pins;
  logic [4:0]   events;

  prd_reg_if rif ();

  // ----------------------------------------------------------------
  // Register access functions
  // ----------------------------------------------------------------
  function automatic prd_main_type reg_write(
    input prd_main_type st,
    input logic [6:0]   a,
    input logic [7:0]   d
  );
    prd_main_type r;
    r = st;
    case (a)
      prd_pkg::REG_STAT_SEL: begin
        r.stat_sel = d[3:0];
      end
      prd_pkg::REG_REF_DIV: begin
        r.ref_div = d[prd_pkg::RD_W-1:0];
        r.restart = 1'b1;
      end
      prd_pkg::REG_REF_CFG: begin
        r.ref_filter_select = d[prd_pkg::CFG_REF_FILTER_SELECT_LSB +: 2];
        r.boost = d[prd_pkg::CFG_BOOST];
        r.dsm_off = d[prd_pkg::CFG_DSM_OFF];
      end
      prd_pkg::REG_IRQ_STAT: begin
        r.irq_stat = st.irq_stat & ~d[prd_pkg::EV_W-1:0];
      end
      prd_pkg::REG_IRQ_MASK: begin
        r.irq_mask = d[prd_pkg::EV_W-1:0];
      end
      default: begin
        r.restart = st.restart;
      end
    endcase
    return r;
  endfunction

  function automatic logic [7:0] reg_read(
    input prd_main_type st,
    input logic [6:0]   a
  );
    logic [7:0] v;
    v = 8'h00;
    case (a)
      prd_pkg::REG_STATUS: begin
        v[3:0] = st.flag_q;
        v[prd_pkg::BIT_REF_LOST] = st.ref_lost;
      end
      prd_pkg::REG_STAT_SEL: begin
        v[3:0] = st.stat_sel;
      end
      prd_pkg::REG_REF_DIV: begin
        v[prd_pkg::RD_W-1:0] = st.ref_div;
      end
      prd_pkg::REG_REF_CFG: begin
        v[prd_pkg::CFG_REF_FILTER_SELECT_LSB +: 2] = st.ref_filter_select;
        v[prd_pkg::CFG_BOOST] = st.boost;
        v[prd_pkg::CFG_DSM_OFF] = st.dsm_off;
      end
      prd_pkg::REG_IRQ_STAT: begin
        v[prd_pkg::EV_W-1:0] = st.irq_stat;
      end
      prd_pkg::REG_IRQ_MASK: begin
        v[prd_pkg::EV_W-1:0] = st.irq_mask;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Pin grouping
  // ----------------------------------------------------------------
  always_comb begin
    flag_pins = 4'h0;
    flag_pins[prd_pkg::BIT_OUT_OF_LOCK] = OUT_OF_LOCK_FLAG;
    flag_pins[prd_pkg::BIT_IN_LOCK] = IN_LOCK_FLAG;
    flag_pins[prd_pkg::BIT_HIGH_CLAMP] = HIGH_CLAMP_FLAG;
    flag_pins[prd_pkg::BIT_LOW_CLAMP] = LOW_CLAMP_FLAG;
  end

  assign events = {s.ref_lost & ~s.ref_lost_d, s.flag_q & ~s.flag_d};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.restart = 1'b0;
    next_s.flag_m = flag_pins;
    next_s.flag_q = s.flag_m;
    next_s.flag_d = s.flag_q;
    next_s.ref_m = REF_IN;
    next_s.ref_q = s.ref_m;
    next_s.ref_d = s.ref_q;
    next_s.ref_rise = s.ref_q & ~s.ref_d;
    next_s.mute_m = MUTE_N;
    next_s.mute_q = s.mute_m;
    next_s.ref_lost_d = s.ref_lost;
    if (s.ref_rise) begin
      next_s.ref_idle = 12'h000;
      next_s.ref_lost = 1'b0;
    end else if (s.ref_idle == prd_pkg::REF_LOSS_CYC) begin
      next_s.ref_lost = 1'b1;
    end else begin
      next_s.ref_idle = s.ref_idle + 12'h001;
    end
    if (WR) begin
      next_s = reg_write(next_s, ADDR, WDATA);
    end
    if (rif.wr) begin
      next_s = reg_write(next_s, rif.addr, rif.wdata);
    end
    // Set wins over clear
    next_s.irq_stat = next_s.irq_stat | events;
    next_s.rdata = RD ? reg_read(s, ADDR) : 8'h00;
    next_s.stat = |(s.flag_q & s.stat_sel);
    next_s.irq = |(s.irq_stat & s.irq_mask);
    next_s.rf_mute = ~s.mute_q;
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s <= MAIN_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rif.rdata = reg_read(s, rif.addr);

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  prd_spi_slave u_spi (
    .clk    (MCLK),
    .rst    (SYS_RST),
    .cs_n   (CS_N),
    .sclk   (SCLK),
    .sdi    (SDI),
    .sdo    (SDO),
    .sdo_oe (SDO_OE),
    .rif    (rif.spi)
  );

  prd_ref_div #(
    .W (prd_pkg::RD_W)
  ) u_div (
    .clk      (MCLK),
    .rst      (SYS_RST),
    .ref_rise (s.ref_rise),
    .ratio    (s.ref_div),
    .restart  (s.restart),
    .pulse    (PFD_REF_PULSE)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign RDATA             = s.rdata;
  assign STAT              = s.stat;
  assign IRQ               = s.irq;
  assign RF_MUTE           = s.rf_mute;
  assign DSM_OFF           = s.dsm_off;
  assign REF_FILTER_SELECT = s.ref_filter_select;
  assign REF_GAIN_BOOST    = s.boost;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);

  a_stat_or: assert property (|(s.flag_q & s.stat_sel) |=> STAT)
    else $error("Status pin missed a selected flag");
  a_stat_low: assert property ((s.flag_q & s.stat_sel) == 4'h0 |=> !STAT)
    else $error("Status pin high with no selected flag");
  a_status_read: assert property (RD && ADDR == prd_pkg::REG_STATUS
      |=> RDATA[1:0] == $past(s.flag_q[1:0]))
    else $error("Lock flags misread");
  a_mute_pin: assert property (!s.mute_q |=> RF_MUTE ##1 (RF_MUTE || s.mute_q))
    else $error("Output not muted");
  a_dsm_write: assert property (WR && !rif.wr && ADDR == prd_pkg::REG_REF_CFG
      |=> DSM_OFF == $past(WDATA[prd_pkg::CFG_DSM_OFF]))
    else $error("Modulator control not updated");
  a_ratio_write: assert property (WR && !rif.wr && ADDR == prd_pkg::REG_REF_DIV
      |=> s.restart && s.ref_div == $past(WDATA[4:0]))
    else $error("Ratio not taken as written");
  a_irq_sticky: assert property (events[0] |=> s.irq_stat[0])
    else $error("Event lost");
  a_irq_level: assert property ((s.irq_stat & s.irq_mask) != 5'h00 |=> IRQ)
    else $error("Interrupt not raised");
  a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
    else $error("Read data outside its cycle");
  c_irq: cover property (IRQ);
  c_spi_div: cover property (rif.wr && rif.addr == prd_pkg::REG_REF_DIV);

  // ----------------------------------------------------------------
  // Register, mute and reference loss checks
  // ----------------------------------------------------------------
  a_sel_write: assert property (WR && !rif.wr && ADDR == prd_pkg::REG_STAT_SEL
      |=> s.stat_sel == $past(WDATA[3:0]))
    else $error("Flag select not stored");
  a_cfg_write: assert property (WR && !rif.wr && ADDR == prd_pkg::REG_REF_CFG
      |=> REF_FILTER_SELECT == $past(WDATA[1:0]) && REF_GAIN_BOOST == $past(WDATA[2]))
    else $error("Reference settings not stored");
  a_mask_write: assert property (WR && !rif.wr && ADDR == prd_pkg::REG_IRQ_MASK
      |=> s.irq_mask == $past(WDATA[4:0]))
    else $error("Mask not stored");
  a_irq_clear: assert property (WR && !rif.wr && ADDR == prd_pkg::REG_IRQ_STAT && events == 5'h00
      |=> (s.irq_stat & $past(WDATA[4:0])) == 5'h00)
    else $error("Status bit not cleared");
  a_irq_low: assert property ((s.irq_stat & s.irq_mask) == 5'h00
      |=> !IRQ)
    else $error("Interrupt without unmasked status");
  a_lost_set: assert property (s.ref_idle == prd_pkg::REF_LOSS_CYC && !s.ref_rise
      |=> s.ref_lost)
    else $error("Reference loss not flagged");
  a_lost_clear: assert property (s.ref_rise
      |=> !s.ref_lost && s.ref_idle == 12'h000)
    else $error("Reference loss not cleared");
  a_lost_event: assert property (events[prd_pkg::BIT_REF_LOST]
      |=> s.irq_stat[prd_pkg::BIT_REF_LOST])
    else $error("Reference loss event lost");
  a_mute_off: assert property (s.mute_q |=> !RF_MUTE)
    else $error("Output muted with pin high");
  a_spi_ratio: assert property (rif.wr && rif.addr == prd_pkg::REG_REF_DIV
      |=> s.restart && s.ref_div == $past(rif.wdata[4:0]))
    else $error("Serial ratio not taken as written");
  a_ratio_read: assert property (RD && ADDR == prd_pkg::REG_REF_DIV
      |=> RDATA == {3'h0, $past(s.ref_div)})
    else $error("Ratio misread");
  a_clamp_read: assert property (RD && ADDR == prd_pkg::REG_STATUS
      |=> RDATA[4:2] == $past({s.ref_lost, s.flag_q[3:2]}))
    else $error("Status flags misread");
  c_ref_lost: cover property (events[prd_pkg::BIT_REF_LOST]);
endmodule
`default_nettype wire

/* File: prd_pkg.sv */
// Shared constants and types of the reference divider and control block
package prd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int RD_W   = 5;
  localparam int EV_W   = 5;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] REG_STATUS   = 7'h00;
  localparam logic [6:0] REG_STAT_SEL = 7'h01;
  localparam logic [6:0] REG_REF_DIV  = 7'h06;
  localparam logic [6:0] REG_REF_CFG  = 7'h0B;
  localparam logic [6:0] REG_IRQ_STAT = 7'h10;
  localparam logic [6:0] REG_IRQ_MASK = 7'h11;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_OUT_OF_LOCK = 0;
  localparam int BIT_IN_LOCK     = 1;
  localparam int BIT_HIGH_CLAMP  = 2;
  localparam int BIT_LOW_CLAMP   = 3;
  localparam int BIT_REF_LOST    = 4;
  localparam int CFG_REF_FILTER_SELECT_LSB    = 0;
  localparam int CFG_BOOST       = 2;
  localparam int CFG_DSM_OFF     = 3;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [4:0]  RD_RESET       = 5'h01;
  localparam logic [3:0]  STAT_SEL_RESET = 4'h1;
  localparam logic [4:0]  MASK_RESET     = 5'h00;
  localparam logic [3:0]  FRAME_BITS     = 4'h8;
  localparam logic [11:0] REF_LOSS_CYC   = 12'h400;

  typedef enum logic [2:0] {
    SPI_IDLE = 3'b001,
    SPI_ADDR = 3'b010,
    SPI_DATA = 3'b100
  } prd_spi_state_type;

endpackage

/* File: prd_reg_if.sv */
// Register access carrier between the serial slave and the register file
`timescale 1ns/1ps
`default_nettype none
interface prd_reg_if;
  logic                       wr;
  logic [prd_pkg::ADDR_W-1:0] addr;
  logic [prd_pkg::DATA_W-1:0] wdata;
  logic [prd_pkg::DATA_W-1:0] rdata;
  modport spi  (output wr, output addr, output wdata, input rdata);
  modport regs (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: prd_spi_slave.sv */
// Serial control port slave, oversampled by the system clock
`timescale 1ns/1ps
`default_nettype none
module prd_spi_slave (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Serial pins
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic sdi,
  output logic      sdo,
  output logic      sdo_oe,
  // Register access
  prd_reg_if.spi    rif
);
  typedef struct packed {
    logic                       cs_m, cs_q, sck_m, sck_q, sck_d, sdi_m, sdi_q;
    prd_pkg::prd_spi_state_type st;
    logic [3:0]                 cnt;
    logic [7:0]                 sh;
    logic                       rw, load, sdo, oe, wr;
    logic [6:0]                 addr;
    logic [7:0]                 wdata;
  } prd_spi_type;

  localparam prd_spi_type SPI_RST = '{cs_m: 1'b1, cs_q: 1'b1, st: prd_pkg::SPI_IDLE, default: '0};
  localparam logic [3:0]  LAST    = prd_pkg::FRAME_BITS - 4'h1;

  prd_spi_type s;
  prd_spi_type next_s;
  logic        rise;
  logic        fall;

  assign rise = s.sck_q & ~s.sck_d;
  assign fall = ~s.sck_q & s.sck_d;

  always_comb begin
    next_s = s;
    next_s.wr = 1'b0;
    next_s.cs_m = cs_n;
    next_s.cs_q = s.cs_m;
    next_s.sck_m = sclk;
    next_s.sck_q = s.sck_m;
    next_s.sck_d = s.sck_q;
    next_s.sdi_m = sdi;
    next_s.sdi_q = s.sdi_m;
    if (s.load) begin
      next_s.load = 1'b0;
      next_s.sh = rif.rdata;
      next_s.sdo = rif.rdata[7];
    end
    if (s.cs_q) begin
      next_s.st = prd_pkg::SPI_IDLE;
      next_s.oe = 1'b0;
      next_s.cnt = 4'h0;
      next_s.load = 1'b0;
    end else begin
      unique case (s.st)
        prd_pkg::SPI_IDLE: begin
          next_s.st = prd_pkg::SPI_ADDR;
          next_s.cnt = 4'h0;
        end
        prd_pkg::SPI_ADDR: begin
          if (rise) begin
            next_s.sh = {s.sh[6:0], s.sdi_q};
            next_s.cnt = s.cnt + 4'h1;
            if (s.cnt == LAST) begin
              next_s.addr = s.sh[6:0];
              next_s.rw = s.sdi_q;
              next_s.cnt = 4'h0;
              next_s.st = prd_pkg::SPI_DATA;
              next_s.oe = s.sdi_q;
              next_s.load = s.sdi_q;
            end
          end
        end
        prd_pkg::SPI_DATA: begin
          if (rise) begin
            next_s.cnt = s.cnt + 4'h1;
            if (!s.rw) begin
              next_s.sh = {s.sh[6:0], s.sdi_q};
            end
            if (s.cnt == LAST) begin
              next_s.st = prd_pkg::SPI_ADDR;
              next_s.cnt = 4'h0;
              next_s.oe = 1'b0;
              next_s.wr = ~s.rw;
              next_s.wdata = {s.sh[6:0], s.sdi_q};
            end
          end else if (fall && s.rw && s.cnt != 4'h0) begin
            next_s.sh = {s.sh[6:0], 1'b0};
            next_s.sdo = s.sh[6];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= SPI_RST;
    end else begin
      s <= next_s;
    end
  end

  assign sdo       = s.sdo;
  assign sdo_oe    = s.oe;
  assign rif.wr    = s.wr;
  assign rif.addr  = s.addr;
  assign rif.wdata = s.wdata;

  a_sdo_quiet: assert property (@(posedge clk) disable iff (rst) s.cs_q |=> !sdo_oe)
    else $error("SDO driven outside a frame");
  a_wr_framed: assert property (@(posedge clk) disable iff (rst) rif.wr |-> !$past(s.cs_q))
    else $error("Write issued outside a frame");
  c_spi_read: cover property (@(posedge clk) disable iff (rst) s.oe && fall);
endmodule
`default_nettype wire

/* File: prd_ref_div.sv */
// Reference divider producing the comparison pulse
`timescale 1ns/1ps
`default_nettype none
module prd_ref_div #(
  parameter int W = prd_pkg::RD_W
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Control
  input  wire logic         ref_rise,
  input  wire logic [W-1:0] ratio,
  input  wire logic         restart,
  // Comparison pulse
  output logic              pulse
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pulse;
  } prd_div_type;

  prd_div_type s;
  prd_div_type next_s;

  always_comb begin
    next_s = s;
    next_s.pulse = 1'b0;
    if (restart) begin
      next_s.cnt = '0;
    end else if (ref_rise && ratio != '0) begin
      if (s.cnt == ratio - W'(1)) begin
        next_s.cnt = '0;
        next_s.pulse = 1'b1;
      end else begin
        next_s.cnt = s.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pulse = s.pulse;

  a_pulse_valid: assert property (@(posedge clk) disable iff (rst) pulse |-> $past(ratio) != '0)
    else $error("Pulse with zero ratio");
  a_restart_clr: assert property (@(posedge clk) disable iff (rst) restart |=> !pulse && s.cnt == '0)
    else $error("Divider not restarted");
  c_div_pulse: cover property (@(posedge clk) disable iff (rst) pulse);
endmodule
`default_nettype wire

/* File: prd_top_placeholder_unused.sv */
// Intentionally empty compile unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: prd_host_model.sv */
// Host controller model driving the serial control port
`timescale 1ns/1ps
`default_nettype none
module prd_host_model (
  // Serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  // ----------------------------------------------------------------
  // One frame: address, read flag, data; nb bits then deselect
  // ----------------------------------------------------------------
  task automatic frame(input logic [6:0] a, input logic rw, input logic [7:0] d,
                       input int nb, output logic [7:0] q, output logic oe);
    logic [15:0] w;
    w  = {a, rw, d};
    q  = 8'h00;
    oe = 1'b0;
    #1;
    cs_n = 1'b0;
    #40;
    for (int i = 0; i < nb; i++) begin
      // bit set half period before rise
      sdi = w[15-i];
      #40;
      sclk = 1'b1;
      q    = {q[6:0], sdo};
      oe   = oe | sdo_oe;
      #40;
      sclk = 1'b0;
    end
    #40;
    // select high closes frame, data line left toggled
    cs_n = 1'b1;
    sdi  = ~sdi;
    #80;
  endtask
endmodule
`default_nettype wire

/* File: tb_prd_ref_ctrl.sv */
// Self-checking bench of the reference divider and control block
`timescale 1ns/1ps
`default_nettype none
module tb_prd_ref_ctrl;
  logic       MCLK    = 1'b0;
  logic       SYS_RST = 1'b1;
  logic [6:0] ADDR    = 7'h00;
  logic [7:0] WDATA   = 8'h00;
  logic       WR      = 1'b0;
  logic       RD      = 1'b0;
  logic       MUTE_N  = 1'b1;
  logic [3:0] flg     = 4'h0;
  logic [2:0] ref_cnt = 3'h0;
  logic       ref_stop = 1'b0;
  logic       REF_IN;
  logic [7:0] RDATA;
  logic [1:0] REF_FILTER_SELECT;
  logic       CS_N, SCLK, SDI, SDO, SDO_OE, sdo_w;
  logic       STAT, IRQ, RF_MUTE, DSM_OFF, REF_GAIN_BOOST, PFD_REF_PULSE;
  int         mismatches   = 0;
  int         total_checks = 0;
  int         cycles       = 0;

  initial forever #2 MCLK = ~MCLK;
  // Reference runs at one eighth of the system clock
  always @(posedge MCLK) ref_cnt <= ref_cnt + 3'h1;
  assign REF_IN = ref_cnt[2] & ~ref_stop;
  // Serial output line has a pull-down when released
  assign sdo_w = SDO_OE ? SDO : 1'b0;

  prd_ref_ctrl dut (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CS_N(CS_N), .SCLK(SCLK), .SDI(SDI), .SDO(SDO), .SDO_OE(SDO_OE),
    .OUT_OF_LOCK_FLAG(flg[0]), .IN_LOCK_FLAG(flg[1]), .HIGH_CLAMP_FLAG(flg[2]),
    .LOW_CLAMP_FLAG(flg[3]), .REF_IN(REF_IN), .MUTE_N(MUTE_N), .STAT(STAT), .IRQ(IRQ),
    .RF_MUTE(RF_MUTE), .DSM_OFF(DSM_OFF), .REF_FILTER_SELECT(REF_FILTER_SELECT),
    .REF_GAIN_BOOST(REF_GAIN_BOOST), .PFD_REF_PULSE(PFD_REF_PULSE)
  );
  prd_host_model host (
    .cs_n(CS_N), .sclk(SCLK), .sdi(SDI), .sdo(sdo_w), .sdo_oe(SDO_OE)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    @(posedge MCLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, e);
  endtask
  task automatic settle;
    repeat (8) @(posedge MCLK);
    #1;
  endtask
  task automatic gap(output int g);
    g = 0;
    do begin
      @(posedge MCLK);
      #1;
      g++;
    end while (PFD_REF_PULSE !== 1'b1 && g < 400);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({IRQ, RF_MUTE, DSM_OFF, REF_GAIN_BOOST, REF_FILTER_SELECT, SDO_OE}, 16'h0);
    rchk(prd_pkg::REG_STAT_SEL, 8'h01);
    rchk(prd_pkg::REG_REF_DIV, 8'h01);
    rchk(prd_pkg::REG_REF_CFG, 8'h00);
    rchk(prd_pkg::REG_IRQ_STAT, 8'h00);
    rchk(prd_pkg::REG_IRQ_MASK, 8'h00);
    rchk(7'h7F, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_stat;
    logic [3:0] sel;
    logic [7:0] q;
    logic       oe;
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 2; k++) begin
        sel = (k == 1) ? ~(4'h1 << i) : (4'h1 << i);
        flg <= 4'h1 << i;
        wr(prd_pkg::REG_STAT_SEL, {4'h0, sel});
        settle;
        chk(STAT, sel[i]);
        rchk(prd_pkg::REG_STATUS, {4'h0, 4'h1 << i});
      end
    end
    chk(IRQ, 1'b0);
    flg <= 4'h2;
    settle;
    host.frame(prd_pkg::REG_STATUS, 1'b1, 8'h00, 16, q, oe);
    chk(q, 8'h02);
    flg <= 4'h0;
    wr(prd_pkg::REG_STAT_SEL, 8'h0F);
    settle;
    chk(STAT, 1'b0);
    $display("status test done");
  endtask
  task automatic t_irq;
    wr(prd_pkg::REG_IRQ_STAT, 8'h1F);
    rchk(prd_pkg::REG_IRQ_STAT, 8'h00);
    wr(prd_pkg::REG_IRQ_MASK, 8'h02);
    rchk(prd_pkg::REG_IRQ_MASK, 8'h02);
    flg <= 4'h4;
    settle;
    chk(IRQ, 1'b0);
    rchk(prd_pkg::REG_IRQ_STAT, 8'h04);
    flg <= 4'h6;
    settle;
    chk(IRQ, 1'b1);
    wr(prd_pkg::REG_IRQ_STAT, 8'h02);
    repeat (3) @(posedge MCLK);
    chk(IRQ, 1'b0);
    rchk(prd_pkg::REG_IRQ_STAT, 8'h04);
    flg <= 4'h0;
    $display("interrupt test done");
  endtask
  task automatic t_mute;
    MUTE_N <= 1'b0;
    settle;
    chk(RF_MUTE, 1'b1);
    MUTE_N <= 1'b1;
    settle;
    chk(RF_MUTE, 1'b0);
    $display("mute test done");
  endtask
  task automatic t_cfg;
    logic [7:0] q;
    logic       oe;
    for (logic [4:0] i = 0; i < 16; i++) begin
      if (i[1:0] == 2'h2) continue;
      host.frame(prd_pkg::REG_REF_CFG, 1'b0, {4'h0, i[3:0]}, 16, q, oe);
      chk(oe, 1'b0);
      chk({DSM_OFF, REF_GAIN_BOOST, REF_FILTER_SELECT}, i[3:0]);
      host.frame(prd_pkg::REG_REF_CFG, 1'b1, 8'h00, 16, q, oe);
      chk(q, {4'h0, i[3:0]});
      chk(oe, 1'b1);
      chk(SDO_OE, 1'b0);
    end
    $display("config test done");
  endtask
  task automatic t_div;
    logic [4:0] rs[3] = '{5'h1F, 5'h05, 5'h01};
    int         g;
    foreach (rs[j]) begin
      wr(prd_pkg::REG_REF_DIV, {3'h0, rs[j]});
      gap(g);
      chk(16'(g >= (rs[j] - 1) * 8 && g <= rs[j] * 8 + 12), 16'h1);
      gap(g);
      chk(g[15:0], {8'h0, rs[j], 3'h0});
      rchk(prd_pkg::REG_REF_DIV, {3'h0, rs[j]});
    end
    $display("divider test done");
  endtask
  task automatic t_abort;
    logic [7:0] q;
    logic       oe;
    wr(prd_pkg::REG_REF_DIV, 8'h07);
    host.frame(prd_pkg::REG_REF_DIV, 1'b0, 8'h0A, 12, q, oe);
    rchk(prd_pkg::REG_REF_DIV, 8'h07);
    host.frame(prd_pkg::REG_REF_DIV, 1'b1, 8'h00, 11, q, oe);
    chk(oe, 1'b1);
    chk(SDO_OE, 1'b0);
    host.frame(prd_pkg::REG_REF_DIV, 1'b0, 8'h0A, 16, q, oe);
    rchk(prd_pkg::REG_REF_DIV, 8'h0A);
    $display("abort test done");
  endtask
  task automatic t_lost;
    wr(prd_pkg::REG_IRQ_STAT, 8'h1F);
    wr(prd_pkg::REG_IRQ_MASK, 8'h10);
    ref_stop <= 1'b1;
    repeat (1060) @(posedge MCLK);
    chk(IRQ, 1'b1);
    rchk(prd_pkg::REG_STATUS, 8'h10);
    ref_stop <= 1'b0;
    repeat (20) @(posedge MCLK);
    rchk(prd_pkg::REG_STATUS, 8'h00);
    wr(prd_pkg::REG_IRQ_STAT, 8'h10);
    rchk(prd_pkg::REG_IRQ_STAT, 8'h00);
    chk(IRQ, 1'b0);
    $display("reference loss test done");
  endtask
  task automatic t_ro;
    wr(prd_pkg::REG_STATUS, 8'hFF);
    wr(7'h7F, 8'hFF);
    rchk(prd_pkg::REG_STATUS, 8'h00);
    rchk(7'h7F, 8'h00);
    rchk(prd_pkg::REG_REF_DIV, 8'h0A);
    $display("read-only test done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge MCLK);
    SYS_RST <= 1'b0;
    repeat (3) @(posedge MCLK);
    t_reset;
    t_stat;
    t_irq;
    t_mute;
    t_cfg;
    t_div;
    t_abort;
    t_lost;
    t_ro;
    conclude;
  end
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      conclude;
    end
  end
endmodule
`default_nettype wire
